// file: cp_pkg.sv
// Constants, types and register map for the charge pump enable control
`default_nettype none
package cp_pkg;

  // ==========================================================
  // Bus geometry
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;
  localparam logic [11:0] CTRL_INDEX    = 12'h09a;
  localparam logic [11:0] CTRL_ADDR     = {CTRL_INDEX[9:0], 2'b00};
  localparam logic [11:0] IRQ_STAT_ADDR = 12'h26c;
  localparam logic [11:0] IRQ_MASK_ADDR = 12'h270;

  // ==========================================================
  // Control register fields
  localparam int         MODE_HI     = 7;
  localparam int         MODE_LO     = 6;
  localparam int         THRESH_BIT  = 1;
  localparam int         READY_BIT   = 0;
  localparam logic [1:0] MODE_RESET  = 2'h0;
  localparam logic [3:0] GAP_ZERO    = 4'h0;
  localparam logic [23:0] HIGH_ZERO  = 24'h000000;

  // Analog trip point, informative only: the comparator lives outside
  localparam int AUTO_THRESHOLD_VOLTAGE_MV = 4096;

  // ==========================================================
  // Interrupt events
  localparam int         EV_READY   = 0;
  localparam int         EV_THRESH  = 1;
  localparam int         EV_PUMP    = 2;
  localparam int         EV_W       = 3;
  localparam logic [2:0] EV_RESET   = 3'h0;
  localparam logic [28:0] EV_PAD    = 29'h00000000;

  // ==========================================================
  // Synchronised analog inputs
  localparam int SYNC_W      = 2;
  localparam int SIG_BELOW   = 0;
  localparam int SIG_SETTLED = 1;

  typedef enum logic [1:0] {
    CP_MODE_OFF   = 2'b00,
    CP_MODE_GATED = 2'b01,
    CP_MODE_AUTO  = 2'b10,
    CP_MODE_ON    = 2'b11
  } cp_mode_type;

  typedef enum logic [1:0] {
    CP_PUMP_OFF,
    CP_PUMP_SETTLE,
    CP_PUMP_READY
  } cp_pump_state_type;

endpackage
`default_nettype wire

// file: cp_sync_if.sv
// Carrier between the control block and its input synchroniser
`default_nettype none
interface cp_sync_if #(parameter int WIDTH = 2);
  logic [WIDTH-1:0] raw;
  logic [WIDTH-1:0] sync;
  modport syncer (input raw, output sync);
  modport user   (output raw, input sync);
endinterface
`default_nettype wire

// file: cp_sync.sv
// Two-stage synchroniser for the analog status inputs
`default_nettype none
module cp_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_b,
  // Signals
  cp_sync_if.syncer bus
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
        stage1[i] <= 1'b0;
        stage2[i] <= 1'b0;
      end else begin
        stage1[i] <= bus.raw[i];
        stage2[i] <= stage1[i];
      end
    end
  end

  assign bus.sync = stage2;

endmodule
`default_nettype wire

// file: cp_ctrl.sv
// Charge pump enable control with APB register slave and interrupt
//
// Our own choice: the APB register port.
`default_nettype none
module cp_ctrl (
  // Clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       rst_b,
  // APB slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [cp_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [cp_pkg::DATA_W-1:0]  pwdata,
  output logic      [cp_pkg::DATA_W-1:0]  prdata,
  output logic                            pready,
  output logic                            pslverr,
  // Analog side
  input  wire logic                       supply_below_raw,
  input  wire logic                       pump_settled_raw,
  input  wire logic                       converter_enable,
  output logic                            pump_enable,
  // Interrupt
  output logic                            irq
);

  // ==========================================================
  // Input synchronisation
  cp_sync_if #(.WIDTH(cp_pkg::SYNC_W)) sync_bus ();

  assign sync_bus.raw[cp_pkg::SIG_BELOW]   = supply_below_raw;
  assign sync_bus.raw[cp_pkg::SIG_SETTLED] = pump_settled_raw;

  cp_sync #(.WIDTH(cp_pkg::SYNC_W)) u_sync (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .bus     (sync_bus.syncer)
  );

  logic below_s;
  logic settled_s;
  assign below_s   = sync_bus.sync[cp_pkg::SIG_BELOW];
  assign settled_s = sync_bus.sync[cp_pkg::SIG_SETTLED];

  // ==========================================================
  // Elaboration checks
  // Input map and event bits are fixed positions; refuse a package that cannot hold them
  if (cp_pkg::SYNC_W <= cp_pkg::SIG_SETTLED || cp_pkg::SYNC_W <= cp_pkg::SIG_BELOW ||
      cp_pkg::EV_W <= cp_pkg::EV_PUMP) begin : g_cfg_check
    $error("cp_ctrl package widths do not fit the input map or event bits");
  end

  // ==========================================================
  // Register state
  cp_pkg::cp_mode_type       mode;
  cp_pkg::cp_pump_state_type state;
  cp_pkg::cp_pump_state_type next_state;
  logic                      thresh_status;
  logic                      ready_status;
  logic [cp_pkg::EV_W-1:0]   irq_status;
  logic [cp_pkg::EV_W-1:0]   irq_mask;
  logic [cp_pkg::EV_W-1:0]   events;
  logic                      want_on;
  logic                      next_ready;
  logic                      irq_pending;
  logic [1:0]                wr_mode;

  // ==========================================================
  // APB decode
  logic access;
  logic done;
  logic wr_done;
  logic rd_done;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_mask;
  logic hit_any;

  assign access   = psel && penable && !pready;
  assign done     = psel && penable && pready;
  assign wr_done  = done && pwrite;
  assign rd_done  = done && !pwrite;
  assign hit_ctrl = (paddr == cp_pkg::CTRL_ADDR);
  assign hit_stat = (paddr == cp_pkg::IRQ_STAT_ADDR);
  assign hit_mask = (paddr == cp_pkg::IRQ_MASK_ADDR);
  assign hit_any  = hit_ctrl || hit_stat || hit_mask;
  assign wr_mode  = pwdata[cp_pkg::MODE_HI:cp_pkg::MODE_LO];

  // One wait state: pready is a flop, so the answer trails the access edge
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= access;
      pslverr <= access && !hit_any;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      prdata <= '0;
    end else if (access && !pwrite) begin
      if (hit_ctrl) begin
        prdata <= {cp_pkg::HIGH_ZERO, mode, cp_pkg::GAP_ZERO, thresh_status, ready_status};
      end else if (hit_stat) begin
        prdata <= {cp_pkg::EV_PAD, irq_status};
      end else if (hit_mask) begin
        prdata <= {cp_pkg::EV_PAD, irq_mask};
      end else begin
        prdata <= '0;
      end
    end
  end

  // ==========================================================
  // Mode field
  // Reset to off, writes take effect
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      mode <= cp_pkg::cp_mode_type'(cp_pkg::MODE_RESET);
    end else if (wr_done && hit_ctrl) begin
      mode <= cp_pkg::cp_mode_type'(pwdata[cp_pkg::MODE_HI:cp_pkg::MODE_LO]);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irq_mask <= cp_pkg::EV_RESET;
    end else if (wr_done && hit_mask) begin
      irq_mask <= pwdata[cp_pkg::EV_W-1:0];
    end
  end

  // ==========================================================
  // Enable decision
  always_comb begin
    case (mode)
      cp_pkg::CP_MODE_ON:    want_on = 1'b1;
      cp_pkg::CP_MODE_AUTO:  want_on = below_s;
      cp_pkg::CP_MODE_GATED: want_on = below_s && converter_enable;
      cp_pkg::CP_MODE_OFF:   want_on = 1'b0;
      default:               want_on = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pump_enable <= 1'b0;
    end else begin
      pump_enable <= want_on;
    end
  end

  // ==========================================================
  // Settling tracker
  always_comb begin
    next_state = state;
    case (state)
      cp_pkg::CP_PUMP_OFF: begin
        if (pump_enable) begin
          next_state = cp_pkg::CP_PUMP_SETTLE;
        end
      end
      cp_pkg::CP_PUMP_SETTLE: begin
        if (!pump_enable) begin
          next_state = cp_pkg::CP_PUMP_OFF;
        end else if (settled_s) begin
          next_state = cp_pkg::CP_PUMP_READY;
        end
      end
      cp_pkg::CP_PUMP_READY: begin
        if (!pump_enable) begin
          next_state = cp_pkg::CP_PUMP_OFF;
        end else if (!settled_s) begin
          next_state = cp_pkg::CP_PUMP_SETTLE;
        end
      end
      default: next_state = cp_pkg::CP_PUMP_OFF;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state <= cp_pkg::CP_PUMP_OFF;
    end else begin
      state <= next_state;
    end
  end

  // Ready falls with the enable, never a cycle after the pump stops
  assign next_ready = (next_state == cp_pkg::CP_PUMP_READY) && want_on;

  // Ready only once settled and running
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ready_status <= 1'b0;
    end else begin
      ready_status <= next_ready;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      thresh_status <= 1'b0;
    end else begin
      thresh_status <= !below_s;
    end
  end

  // ==========================================================
  // Interrupts
  always_comb begin
    events                   = '0;
    events[cp_pkg::EV_READY]  = next_ready && !ready_status;
    events[cp_pkg::EV_THRESH] = (!below_s) != thresh_status;
    events[cp_pkg::EV_PUMP]   = want_on != pump_enable;
  end

  // Set beats the read clear so a coincident event survives
  for (genvar i = 0; i < cp_pkg::EV_W; i++) begin : g_ev
    always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
        irq_status[i] <= 1'b0;
      end else if (events[i]) begin
        irq_status[i] <= 1'b1;
      end else if (rd_done && hit_stat) begin
        irq_status[i] <= 1'b0;
      end
    end
  end

  assign irq_pending = |(irq_status & irq_mask);

  // Registered output: one cycle behind the status bits
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_pending;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_forced_on_mode: assert property (
    mode == cp_pkg::CP_MODE_ON |=> pump_enable)
    else $error("pump not on in forced mode");

  a_auto_follows_supply: assert property (
    mode == cp_pkg::CP_MODE_AUTO |=> pump_enable == $past(below_s))
    else $error("auto mode does not follow supply");

  a_gated_needs_conv: assert property (
    mode == cp_pkg::CP_MODE_GATED && below_s && converter_enable |=> pump_enable)
    else $error("gated mode failed to start pump");

  a_gated_stops_pump: assert property (
    mode == cp_pkg::CP_MODE_GATED && (!below_s || !converter_enable) |=> !pump_enable)
    else $error("gated mode failed to stop pump");

  a_off_write_stops: assert property (
    wr_done && hit_ctrl && pwdata[cp_pkg::MODE_HI:cp_pkg::MODE_LO] == cp_pkg::MODE_RESET
    |=> ##1 !pump_enable)
    else $error("pump still on after writing off");

  a_thresh_bit_value: assert property (
    $past(rst_b) |-> thresh_status == !$past(below_s))
    else $error("threshold bit does not track supply");

  a_ready_needs_pump: assert property (
    ready_status |-> pump_enable && $past(settled_s))
    else $error("ready without settled running pump");

  a_ctrl_read_layout: assert property (
    access && !pwrite && hit_ctrl |=> pready && prdata[5:2] == cp_pkg::GAP_ZERO
    && prdata[cp_pkg::MODE_HI:cp_pkg::MODE_LO] == $past(mode)
    && prdata[cp_pkg::THRESH_BIT] == $past(thresh_status))
    else $error("control read data wrong");

  a_sync_two_stage: assert property (
    $past(rst_b, 3) |-> below_s == $past(supply_below_raw, 2)
    && settled_s == $past(pump_settled_raw, 2))
    else $error("synchroniser latency wrong");

  a_irq_from_mask: assert property (
    irq == $past(irq_pending))
    else $error("interrupt level mismatch");

  a_ready_off_pump: assert property (
    !pump_enable |-> !ready_status)
    else $error("ready set while pump is off");

  a_ready_event_sets: assert property (
    $rose(ready_status) |-> irq_status[cp_pkg::EV_READY])
    else $error("ready rise not recorded");

  a_off_mode_idle: assert property (
    mode == cp_pkg::CP_MODE_OFF |=> !pump_enable)
    else $error("pump on in off mode");

  a_mode_write_lands: assert property (
    wr_done && hit_ctrl |=> mode == $past(wr_mode))
    else $error("mode write lost");

  a_unmapped_error: assert property (
    access && !hit_any |=> pready && pslverr && (pwrite || prdata == '0))
    else $error("unmapped access not refused");

  a_unmapped_write_kept: assert property (
    wr_done && !hit_any |=> $stable(mode) && $stable(irq_mask))
    else $error("unmapped write changed state");

  a_pready_one_cycle: assert property (
    pready |=> !pready)
    else $error("pready longer than one cycle");

  a_pready_needs_access: assert property (
    pready |-> $past(access))
    else $error("pready without access");

  a_pslverr_with_pready: assert property (
    pslverr |-> pready)
    else $error("pslverr outside a response");

  a_pump_event_sets: assert property (
    events[cp_pkg::EV_PUMP] |=> irq_status[cp_pkg::EV_PUMP])
    else $error("pump change event lost");

  a_read_clears_stat: assert property (
    rd_done && hit_stat && events == '0 |=> irq_status == '0)
    else $error("status read did not clear");

  c_pump_reaches_ready: cover property (
    state == cp_pkg::CP_PUMP_SETTLE ##1 state == cp_pkg::CP_PUMP_READY);
  c_gated_pump_on: cover property (
    mode == cp_pkg::CP_MODE_GATED && pump_enable);
  c_irq_raised: cover property (!irq ##1 irq);
  c_unmapped_error: cover property (pready && pslverr);
  c_gated_cut_off: cover property (
    mode == cp_pkg::CP_MODE_GATED && pump_enable ##1 !pump_enable);

endmodule
`default_nettype wire

// file: cp_pump_model.sv
// Behavioural analog side: supply comparator and a settling charge pump
`default_nettype none
module cp_pump_model (
  // Clock
  input  wire logic       ref_clk,
  // Bench stimulus
  input  wire logic       supply_low,
  input  wire logic [3:0] settle_cycles,
  // Pump control and status
  input  wire logic       pump_enable,
  output logic            supply_below_raw,
  output logic            pump_settled_raw
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] settle_count;
  initial begin
    supply_below_raw = 1'b1;
    pump_settled_raw = 1'b0;
    settle_count = 4'h0;
  end
  // ==========================================================
  // Settling
  // A slow pump is only a longer count; a stopped pump loses readiness
  always @(posedge ref_clk) begin
    supply_below_raw <= supply_low;
    if (pump_enable !== 1'b1) begin
      settle_count <= 4'h0;
      pump_settled_raw <= 1'b0;
    end else if (settle_count >= settle_cycles) begin
      pump_settled_raw <= 1'b1;
    end else begin
      settle_count <= settle_count + 4'h1;
    end
  end
endmodule
`default_nettype wire

// file: cp_ctrl_test.sv
// Self-checking bench for the charge pump enable control
`default_nettype none
module cp_ctrl_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, irq;
  logic        converter_enable, supply_low, supply_below_raw, pump_settled_raw;
  logic        pump_enable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  settle_cycles;
  logic [33:0] exp_q[$];
  int          failures, samples_checked;

  cp_ctrl cp_ctrl_inst (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .supply_below_raw(supply_below_raw),
    .pump_settled_raw(pump_settled_raw), .converter_enable(converter_enable),
    .pump_enable(pump_enable), .irq(irq));
  cp_pump_model cp_pump_model_inst (.ref_clk(ref_clk), .supply_low(supply_low),
    .settle_cycles(settle_cycles), .pump_enable(pump_enable),
    .supply_below_raw(supply_below_raw), .pump_settled_raw(pump_settled_raw));

  always #20 ref_clk = ~ref_clk;

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // ==========================================================
  // APB master: expectation noted at setup, held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic chk, input logic err, input logic [31:0] exp);
    int n;
    exp_q.push_back({chk, err, exp});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      failures++;
      $display("[FAIL] pready expected 1 seen none");
      results();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  // ==========================================================
  // Monitor: oldest note against each completed transfer
  always @(posedge ref_clk) begin
    logic [33:0] e;
    if (rst_b === 1'b1 && pready === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h3ffffffff;
      cmp("pslverr", {31'h0, e[32]}, {31'h0, pslverr}); // bus response
      if (e[33]) cmp("prdata", e[31:0], prdata); // register read
    end
  end

  initial begin
    logic [1:0]  m;
    logic        lo, cv, on;
    logic [31:0] r;
    ref_clk = 1'b0;
    rst_b = 1'b0;
    {psel, penable, pwrite, converter_enable} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    supply_low = 1'b1;
    settle_cycles = 4'h2;
    failures = 0;
    samples_checked = 0;
    r = $urandom(34);
    tick(4);
    rst_b <= 1'b1;
    // Let the synchronisers fill before the first status read
    tick(4);
    apb(1'b0, cp_pkg::CTRL_ADDR, 32'h0, 1'b1, 1'b0, 32'h0); // reset value
    cmp("pump_enable", 32'h0, {31'h0, pump_enable}); // pump off
    $display("test reset done");
    // Every mode against both supply levels and converter states
    for (int i = 0; i < 16; i++) begin
      m = i[3:2];
      lo = i[1];
      cv = i[0];
      r = $urandom;
      on = (m == 2'h3) | (m == 2'h2 & lo) | (m == 2'h1 & lo & cv);
      settle_cycles <= 4'($urandom_range(1, 8));
      supply_low <= lo;
      converter_enable <= cv;
      apb(1'b1, cp_pkg::CTRL_ADDR, {r[31:8], m, r[5:0]}, 1'b0, 1'b0, 32'h0);
      tick(20);
      cmp("pump_enable", {31'h0, on}, {31'h0, pump_enable}); // mode
      apb(1'b0, cp_pkg::CTRL_ADDR, 32'h0, 1'b1, 1'b0, {24'h0, m, 4'h0, ~lo, on}); // bits
    end
    $display("test modes done");
    // Gated mode: unsettled pump, then converter switched off
    settle_cycles <= 4'h8;
    // Stop the pump first so the gated start has to settle again
    apb(1'b1, cp_pkg::CTRL_ADDR, 32'h0, 1'b0, 1'b0, 32'h0);
    tick(4);
    cmp("pump_enable", 32'h0, {31'h0, pump_enable}); // off write
    apb(1'b1, cp_pkg::CTRL_ADDR, 32'h40, 1'b0, 1'b0, 32'h0);
    apb(1'b0, cp_pkg::CTRL_ADDR, 32'h0, 1'b1, 1'b0, 32'h40); // still settling
    tick(20);
    cmp("pump_enable", 32'h1, {31'h0, pump_enable}); // gated on
    converter_enable <= 1'b0;
    tick(2);
    cmp("pump_enable", 32'h0, {31'h0, pump_enable}); // converter off
    supply_low <= 1'b0;
    converter_enable <= 1'b1;
    tick(20);
    cmp("pump_enable", 32'h0, {31'h0, pump_enable}); // supply recovered
    $display("test gated done");
    apb(1'b0, 12'h004, 32'h0, 1'b1, 1'b1, 32'h0); // unmapped read
    apb(1'b1, 12'h008, $urandom, 1'b0, 1'b1, 32'h0); // unmapped write
    $display("test unmapped done");
    // Interrupt: raise, clear by read, mask, unmask
    apb(1'b0, cp_pkg::IRQ_STAT_ADDR, 32'h0, 1'b0, 1'b0, 32'h0);
    apb(1'b1, cp_pkg::IRQ_MASK_ADDR, 32'h4, 1'b0, 1'b0, 32'h0);
    apb(1'b0, cp_pkg::IRQ_MASK_ADDR, 32'h0, 1'b1, 1'b0, 32'h4);
    apb(1'b1, cp_pkg::CTRL_ADDR, 32'hc0, 1'b0, 1'b0, 32'h0);
    tick(20);
    cmp("irq", 32'h1, {31'h0, irq});
    apb(1'b0, cp_pkg::IRQ_STAT_ADDR, 32'h0, 1'b1, 1'b0, 32'h5);
    tick(3);
    cmp("irq", 32'h0, {31'h0, irq});
    apb(1'b1, cp_pkg::IRQ_MASK_ADDR, 32'h0, 1'b0, 1'b0, 32'h0);
    apb(1'b1, cp_pkg::CTRL_ADDR, 32'h0, 1'b0, 1'b0, 32'h0);
    tick(20);
    cmp("pump_enable", 32'h0, {31'h0, pump_enable}); // cleared mode
    cmp("irq", 32'h0, {31'h0, irq});
    apb(1'b1, cp_pkg::IRQ_MASK_ADDR, 32'h4, 1'b0, 1'b0, 32'h0);
    tick(3);
    cmp("irq", 32'h1, {31'h0, irq});
    apb(1'b0, cp_pkg::IRQ_STAT_ADDR, 32'h0, 1'b1, 1'b0, 32'h4);
    tick(3);
    cmp("irq", 32'h0, {31'h0, irq});
    $display("test interrupt done");
    results();
  end
endmodule
`default_nettype wire
